// ---- pkg/tcc_pkg.sv ----
// Shared constants and types for the 8-bit timer compare channels
package tcc_pkg;

  // ********************************
  // Register indices (byte address is four times the index)
  // ********************************
  localparam logic [7:0] IDX_CTL0 = 8'hec;
  localparam logic [7:0] IDX_VAL0 = 8'hed;
  localparam logic [7:0] IDX_CTL1 = 8'hee;
  localparam logic [7:0] IDX_VAL1 = 8'hef;
  localparam logic [7:0] IDX_FLAG = 8'hd8;

  // ********************************
  // Field layout and reset values
  // ********************************
  localparam int CTL_IM_BIT = 6;
  localparam int CTL_ACT_HI = 5;
  localparam int CTL_ACT_LO = 3;
  localparam int CTL_EN_BIT = 2;
  localparam logic [6:0] CTL_RESET = 7'h40;
  localparam logic [7:0] VAL_RESET = 8'h00;
  localparam int FLAG_CH0_BIT = 4;
  localparam int FLAG_CH1_BIT = 5;
  localparam int NUM_CH = 2;

  // ********************************
  // Count landmarks
  // ********************************
  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hff;

  // ********************************
  // Output action codes and bus states
  // ********************************
  typedef enum logic [2:0] {
    ACT_SET = 3'h0,
    ACT_CLR = 3'h1,
    ACT_TGL = 3'h2,
    ACT_UP_SET = 3'h3,
    ACT_UP_CLR = 3'h4,
    ACT_ALT_CLR = 3'h5,
    ACT_ALT_SET = 3'h6,
    ACT_NONE = 3'h7
  } tcc_act_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'h0,
    BUS_ACK = 2'h1
  } tcc_bus_t;

endpackage : tcc_pkg

// ---- hdl/tcc_chan_out.sv ----
// One compare channel output stage
`timescale 1ns/1ps
module tcc_chan_out (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic [2:0] act_i,
  input wire logic match_i,
  input wire logic zero_i,
  input wire logic alt_clr_i,
  input wire logic alt_set_i,
  input wire logic down_i,
  input wire logic updown_i,
  output logic out_o
);

  logic out_reg;
  logic out_next;

  // ********************************
  // Action decode
  // ********************************
  always_comb begin
    out_next = out_reg;
    case (tcc_pkg::tcc_act_t'(act_i))
      tcc_pkg::ACT_SET: begin
        if (match_i) out_next = 1'b1;
      end
      tcc_pkg::ACT_CLR: begin
        if (match_i) out_next = 1'b0;
      end
      tcc_pkg::ACT_TGL: begin
        if (match_i) out_next = ~out_reg;
      end
      tcc_pkg::ACT_UP_SET: begin
        // Match beats zero when the compare value itself is zero
        if (match_i) out_next = !(updown_i && down_i);
        else if (zero_i && !updown_i) out_next = 1'b0;
      end
      tcc_pkg::ACT_UP_CLR: begin
        if (match_i) out_next = updown_i && down_i;
        else if (zero_i && !updown_i) out_next = 1'b1;
      end
      tcc_pkg::ACT_ALT_CLR: begin
        if (match_i) out_next = 1'b1;
        else if (alt_clr_i) out_next = 1'b0;
      end
      tcc_pkg::ACT_ALT_SET: begin
        if (match_i) out_next = 1'b0;
        else if (alt_set_i) out_next = 1'b1;
      end
      default: begin
        out_next = out_reg;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) out_reg <= 1'b0;
    else out_reg <= out_next;
  end

  assign out_o = out_reg;

  // ********************************
  // Checks
  // ********************************
  a_toggle_flip: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (act_i == 3'h2 && match_i) |=> (out_reg != $past(out_reg)))
    else $error("toggle action did not flip output");
  a_unused_holds: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (act_i == 3'h7) |=> $stable(out_reg))
    else $error("unused action changed output");

endmodule : tcc_chan_out

// ---- hdl/tcc_top.sv ----
// Two output-compare channels of an 8-bit timer with a Wishbone register slave
// ********************************
// Notes on behaviour
// - Channel zero compares the count with its compare value on every counter tick while its control bit 2 is one.
// - The channel-zero compare value is an 8-bit read/write register that resets to zero.
// - Codes 000, 001 and 010 set, clear or toggle the output on a match.
// - Code 011 sets on an up match and clears at zero, or clears on a down match in up/down mode.
// - Code 100 clears on an up match and sets at zero, or sets on a down match in up/down mode.
// - On channel zero code 101 sets on a match and clears when the count reaches 0xff.
// - On channel zero code 110 clears on a match and sets when the count reaches 0x00.
// - On channel one code 101 sets on a match and clears when the count equals the channel-zero value.
// - On channel one code 110 clears on a match and sets when the count equals the channel-zero value.
// - The action field sits in control bits 5:3, resets to 000, and code 111 does nothing.
// - Channel zero compares only while its control bit 2 is one, which resets to zero.
// - Channel one compares only while its control bit 2 is one, which resets to zero.
// - A match sets the channel pending flag, software clears it by writing zero, and writing one does nothing.
// - Channel one compares against its own 8-bit value register at 0xef, resetting to zero.
// - The external counter supplies the count, tick, direction and up/down flag; zero and 0xff are decoded from the count here.
// ********************************
`timescale 1ns/1ps
module tcc_top (
  input wire logic SYS_CLK_I,
  input wire logic NRST_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [9:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic [7:0] CNT_I,
  input wire logic CNT_TICK_I,
  input wire logic CNT_DOWN_I,
  input wire logic CNT_UPDOWN_I,
  output logic [1:0] CH_OUT_O,
  output logic [1:0] CH_IRQ_O
);

  // ********************************
  // Bus slave
  // ********************************
  tcc_pkg::tcc_bus_t state_reg;
  tcc_pkg::tcc_bus_t state_next;
  logic ack_reg;
  logic ack_next;
  logic [31:0] rdat_reg;
  logic [31:0] rdat_next;
  logic req;
  logic wr_lane;
  logic [7:0] idx;

  assign req = WB_CYC_I && WB_STB_I && (state_reg == tcc_pkg::BUS_IDLE);
  // Only lane 0 carries data; other lanes are ignored on write
  assign wr_lane = req && WB_WE_I && WB_SEL_I[0];
  assign idx = WB_ADR_I[9:2];

  // ********************************
  // Register state
  // ********************************
  logic [6:0] ctl_reg [tcc_pkg::NUM_CH];
  logic [6:0] ctl_next [tcc_pkg::NUM_CH];
  logic [7:0] val_reg [tcc_pkg::NUM_CH];
  logic [7:0] val_next [tcc_pkg::NUM_CH];
  logic [1:0] flag_reg;
  logic [1:0] flag_next;
  logic [1:0] irq_reg;
  logic [1:0] irq_next;
  logic [1:0] match;
  logic [1:0] chan_out;
  logic [1:0] flag_wdat;

  assign flag_wdat = {WB_DAT_I[tcc_pkg::FLAG_CH1_BIT], WB_DAT_I[tcc_pkg::FLAG_CH0_BIT]};

  // ********************************
  // Channel datapath
  // ********************************
  genvar g;
  generate
    for (g = 0; g < tcc_pkg::NUM_CH; g++) begin : g_ch
      logic en;
      logic alt_clr;
      logic alt_set;
      assign en = ctl_reg[g][tcc_pkg::CTL_EN_BIT];
      assign match[g] = CNT_TICK_I && en && (CNT_I == val_reg[g]);
      if (g == 0) begin : g_ch0
        assign alt_clr = CNT_TICK_I && en && (CNT_I == tcc_pkg::CNT_MAX);
        assign alt_set = CNT_TICK_I && en && (CNT_I == tcc_pkg::CNT_ZERO);
      end else begin : g_chn
        assign alt_clr = CNT_TICK_I && en && (CNT_I == val_reg[0]);
        assign alt_set = alt_clr;
      end
      tcc_chan_out u_out (
        .sys_clk_i(SYS_CLK_I),
        .nrst_i(NRST_I),
        .act_i(ctl_reg[g][tcc_pkg::CTL_ACT_HI:tcc_pkg::CTL_ACT_LO]),
        .match_i(match[g]),
        .zero_i(CNT_TICK_I && en && (CNT_I == tcc_pkg::CNT_ZERO)),
        .alt_clr_i(alt_clr),
        .alt_set_i(alt_set),
        .down_i(CNT_DOWN_I),
        .updown_i(CNT_UPDOWN_I),
        .out_o(chan_out[g])
      );
    end
  endgenerate

  // ********************************
  // Next-state logic
  // ********************************
  always_comb begin
    state_next = state_reg;
    ack_next = 1'b0;
    rdat_next = rdat_reg;
    ctl_next = ctl_reg;
    val_next = val_reg;
    flag_next = flag_reg;
    case (state_reg)
      tcc_pkg::BUS_IDLE: begin
        if (req) begin
          state_next = tcc_pkg::BUS_ACK;
          ack_next = 1'b1;
        end
      end
      tcc_pkg::BUS_ACK: begin
        state_next = tcc_pkg::BUS_IDLE;
      end
      default: begin
        state_next = tcc_pkg::BUS_IDLE;
      end
    endcase
    if (req) begin
      // Unmapped indices read as zero and swallow writes
      case (idx)
        tcc_pkg::IDX_CTL0: rdat_next = {24'h0, 1'b0, ctl_reg[0]};
        tcc_pkg::IDX_CTL1: rdat_next = {24'h0, 1'b0, ctl_reg[1]};
        tcc_pkg::IDX_VAL0: rdat_next = {24'h0, val_reg[0]};
        tcc_pkg::IDX_VAL1: rdat_next = {24'h0, val_reg[1]};
        tcc_pkg::IDX_FLAG: rdat_next = {26'h0, flag_reg, 4'h0};
        default: rdat_next = 32'h0;
      endcase
    end
    if (wr_lane) begin
      case (idx)
        tcc_pkg::IDX_CTL0: ctl_next[0] = WB_DAT_I[6:0];
        tcc_pkg::IDX_CTL1: ctl_next[1] = WB_DAT_I[6:0];
        tcc_pkg::IDX_VAL0: val_next[0] = WB_DAT_I[7:0];
        tcc_pkg::IDX_VAL1: val_next[1] = WB_DAT_I[7:0];
        tcc_pkg::IDX_FLAG: flag_next = flag_reg & flag_wdat;
        default: flag_next = flag_reg;
      endcase
    end
    // A match in the clearing cycle still lands
    flag_next = flag_next | match;
    irq_next[0] = flag_next[0] && ctl_next[0][tcc_pkg::CTL_IM_BIT];
    irq_next[1] = flag_next[1] && ctl_next[1][tcc_pkg::CTL_IM_BIT];
  end

  // ********************************
  // Registers
  // ********************************
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      state_reg <= tcc_pkg::BUS_IDLE;
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0;
      ctl_reg[0] <= tcc_pkg::CTL_RESET;
      ctl_reg[1] <= tcc_pkg::CTL_RESET;
      val_reg[0] <= tcc_pkg::VAL_RESET;
      val_reg[1] <= tcc_pkg::VAL_RESET;
      flag_reg <= 2'h0;
      irq_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
      ack_reg <= ack_next;
      rdat_reg <= rdat_next;
      ctl_reg <= ctl_next;
      val_reg <= val_next;
      flag_reg <= flag_next;
      irq_reg <= irq_next;
    end
  end

  assign WB_ACK_O = ack_reg;
  assign WB_DAT_O = rdat_reg;
  assign CH_IRQ_O = irq_reg;
  assign CH_OUT_O = chan_out;

  // ********************************
  // Checks
  // ********************************
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!NRST_I);

  sequence s_req;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  sequence s_ack_pulse;
    WB_ACK_O ##1 !WB_ACK_O;
  endsequence

  a_bus_ack_once: assert property (s_req |=> s_ack_pulse)
    else $error("bus request not acknowledged for exactly one cycle");
  a_match_sets_flag: assert property (match[0] |=> flag_reg[0])
    else $error("channel zero match did not set its flag");
  a_flag_write_one: assert property (
    (wr_lane && idx == 8'hd8 && WB_DAT_I[5] && match[1] == 1'b0) |=> flag_reg[1] == $past(flag_reg[1]))
    else $error("writing one changed channel one flag");
  // Same-cycle view: a mask write and a flag set in one edge must not leak a request
  a_irq_masked: assert property (!ctl_reg[1][tcc_pkg::CTL_IM_BIT] |-> !CH_IRQ_O[1])
    else $error("masked channel one raised a request");
  a_disabled_quiet: assert property (!ctl_reg[0][2] |-> !match[0])
    else $error("disabled channel zero produced a match");
  a_ch1_enable: assert property (
    (CNT_TICK_I && ctl_reg[1][2] && CNT_I == val_reg[1]) |-> match[1])
    else $error("enabled channel one missed its match");
  a_val_write: assert property (
    (wr_lane && idx == 8'hed) |=> val_reg[0] == $past(WB_DAT_I[7:0]))
    else $error("channel zero compare value not written");
  a_ch0_top_clear: assert property (
    (ctl_reg[0][5:2] == 4'hb && CNT_TICK_I && CNT_I == 8'hff && val_reg[0] != 8'hff) |=> !CH_OUT_O[0])
    else $error("channel zero code 101 did not clear at top");
  a_ch1_alt_set: assert property (
    (ctl_reg[1][5:2] == 4'hd && CNT_TICK_I && CNT_I == val_reg[0] && CNT_I != val_reg[1]) |=> CH_OUT_O[1])
    else $error("channel one code 110 did not set at channel zero value");

  // ********************************
  // Action, flag and map checks
  // ********************************
  sequence s_ch0_up_match;
    CNT_TICK_I && !CNT_DOWN_I && CNT_I == val_reg[0];
  endsequence
  sequence s_ch0_down_match;
    CNT_TICK_I && CNT_DOWN_I && CNT_UPDOWN_I && CNT_I == val_reg[0];
  endsequence

  a_ch0_set_match: assert property (((ctl_reg[0][5:2] == 4'h1) ##0 s_ch0_up_match) |=> CH_OUT_O[0])
    else $error("channel zero code 000 did not set on match");
  a_up_set_match: assert property (((ctl_reg[0][5:2] == 4'h7) ##0 s_ch0_up_match) |=> CH_OUT_O[0])
    else $error("channel zero code 011 did not set on up match");
  a_up_set_down: assert property (((ctl_reg[0][5:2] == 4'h7) ##0 s_ch0_down_match) |=> !CH_OUT_O[0])
    else $error("channel zero code 011 did not clear on down match");
  a_up_clr_match: assert property (((ctl_reg[0][5:2] == 4'h9) ##0 s_ch0_up_match) |=> !CH_OUT_O[0])
    else $error("channel zero code 100 did not clear on up match");
  a_up_clr_down: assert property (((ctl_reg[0][5:2] == 4'h9) ##0 s_ch0_down_match) |=> CH_OUT_O[0])
    else $error("channel zero code 100 did not set on down match");
  a_ch0_zero_set: assert property (
    (ctl_reg[0][5:2] == 4'hd && CNT_TICK_I && CNT_I == 8'h00 && val_reg[0] != 8'h00) |=> CH_OUT_O[0])
    else $error("channel zero code 110 did not set at zero");
  a_ch1_alt_clr: assert property (
    (ctl_reg[1][5:2] == 4'hb && CNT_TICK_I && CNT_I == val_reg[0] && CNT_I != val_reg[1]) |=> !CH_OUT_O[1])
    else $error("channel one code 101 did not clear at channel zero value");
  a_ch0_off_holds: assert property (!ctl_reg[0][tcc_pkg::CTL_EN_BIT] |=> $stable(CH_OUT_O[0]))
    else $error("disabled channel zero changed its output");
  a_ch1_off_holds: assert property (!ctl_reg[1][tcc_pkg::CTL_EN_BIT] |=> $stable(CH_OUT_O[1]))
    else $error("disabled channel one changed its output");
  a_ch1_match_flag: assert property (match[1] |=> flag_reg[1])
    else $error("channel one match did not set its flag");
  a_flag_zero_clear: assert property (
    (wr_lane && idx == tcc_pkg::IDX_FLAG && !WB_DAT_I[4] && !match[0]) |=> !flag_reg[0])
    else $error("writing zero did not clear channel zero flag");
  a_irq0_masked: assert property (!ctl_reg[0][tcc_pkg::CTL_IM_BIT] |-> !CH_IRQ_O[0])
    else $error("masked channel zero raised a request");
  a_irq0_forward: assert property ((flag_reg[0] && ctl_reg[0][tcc_pkg::CTL_IM_BIT]) |-> CH_IRQ_O[0])
    else $error("unmasked pending channel zero gave no request");
  a_ctl_high_zero: assert property (
    (req && (idx == tcc_pkg::IDX_CTL0 || idx == tcc_pkg::IDX_CTL1)) |=> WB_DAT_O[31:7] == 25'h0)
    else $error("control read showed a bit above the mask");
  a_unmapped_zero: assert property ((req && idx == 8'h01) |=> WB_DAT_O == 32'h0)
    else $error("unmapped index read returned nonzero data");

endmodule : tcc_top

// ---- tb/tb_tcc_top.sv ----
// Self-checking bench for the timer compare channels, driven over Wishbone
`timescale 1ns/1ps
module tb_tcc_top;
  logic clk = 1'h0;
  logic nrst = 1'h0;
  logic cyc = 1'h0;
  logic stb = 1'h0;
  logic we = 1'h0;
  logic [9:0] adr = 10'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic [7:0] cnt = 8'h00;
  logic tick = 1'h0;
  logic down = 1'h0;
  logic updn = 1'h0;
  logic [1:0] ch_out;
  logic [1:0] ch_irq;
  logic [31:0] junk;
  int errors = 0;
  int check_count = 0;
  int cycles = 0;
  localparam logic [9:0] A_C0 = {tcc_pkg::IDX_CTL0, 2'h0};
  localparam logic [9:0] A_V0 = {tcc_pkg::IDX_VAL0, 2'h0};
  localparam logic [9:0] A_C1 = {tcc_pkg::IDX_CTL1, 2'h0};
  localparam logic [9:0] A_V1 = {tcc_pkg::IDX_VAL1, 2'h0};
  localparam logic [9:0] A_FL = {tcc_pkg::IDX_FLAG, 2'h0};

  tcc_top DUT (
    .SYS_CLK_I(clk), .NRST_I(nrst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .CNT_I(cnt), .CNT_TICK_I(tick), .CNT_DOWN_I(down), .CNT_UPDOWN_I(updn),
    .CH_OUT_O(ch_out), .CH_IRQ_O(ch_irq)
  );

  always #2.5 clk = ~clk;

  // ********************************
  // Tasks
  // ********************************
  task automatic summarize();
    if (errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Holds the whole request until ack is sampled; the global timeout bounds the wait
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    do @(posedge clk); while (ack !== 1'h1);
    q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    we <= 1'h0;
  endtask : bus

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    bus(1'h1, a, {24'h0, d}, 4'h1, junk);
  endtask : wr

  task automatic rc(input logic [9:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'h0, a, 32'h0, 4'hf, q);
    chk($sformatf("reg %h", a), q, {24'h0, e});
  endtask : rc

  // One counter tick, then the channel output is looked at once it has settled
  task automatic tk(input logic [7:0] c, input logic d, input int ch, input logic e);
    @(posedge clk);
    cnt <= c;
    down <= d;
    tick <= 1'h1;
    @(posedge clk);
    tick <= 1'h0;
    #1;
    chk($sformatf("ch_out %0d", ch), {31'h0, ch_out[ch]}, {31'h0, e});
  endtask : tk

  // ********************************
  // Timeout and main sequence
  // ********************************
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      errors++;
      summarize();
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'h1;
    repeat (2) @(posedge clk);
    #1;
    chk("ch_out", {30'h0, ch_out}, 32'h0);
    chk("ch_irq", {30'h0, ch_irq}, 32'h0);
    rc(A_C0, 8'h40);
    rc(A_V0, 8'h00);
    rc(A_C1, 8'h40);
    rc(A_V1, 8'h00);
    rc(A_FL, 8'h00);
    wr(10'h004, 8'hff);
    rc(10'h004, 8'h00);
    wr(A_V0, 8'h10);
    rc(A_V0, 8'h10);
    bus(1'h1, A_V0, 32'haa, 4'h0, junk);
    rc(A_V0, 8'h10);
    wr(A_C0, 8'hfc);
    rc(A_C0, 8'h7c);
    wr(A_C0, 8'h40);
    tk(8'h10, 1'h0, 0, 1'h0);
    rc(A_FL, 8'h00);
    wr(A_C0, 8'h44);
    tk(8'h10, 1'h0, 0, 1'h1);
    chk("ch_irq", {30'h0, ch_irq}, 32'h1);
    rc(A_FL, 8'h10);
    wr(A_FL, 8'hff);
    rc(A_FL, 8'h10);
    wr(A_FL, 8'h00);
    rc(A_FL, 8'h00);
    wr(A_C0, 8'h4c);
    tk(8'h11, 1'h0, 0, 1'h1);
    tk(8'h10, 1'h0, 0, 1'h0);
    wr(A_C0, 8'h54);
    tk(8'h10, 1'h0, 0, 1'h1);
    tk(8'h10, 1'h0, 0, 1'h0);
    wr(A_C0, 8'h14);
    tk(8'h10, 1'h0, 0, 1'h1);
    chk("ch_irq", {30'h0, ch_irq}, 32'h0);
    rc(A_FL, 8'h10);
    wr(A_FL, 8'h00);
    wr(A_C0, 8'h5c);
    tk(8'h00, 1'h0, 0, 1'h0);
    tk(8'h10, 1'h0, 0, 1'h1);
    @(posedge clk) updn <= 1'h1;
    tk(8'h00, 1'h0, 0, 1'h1);
    tk(8'h10, 1'h1, 0, 1'h0);
    wr(A_C0, 8'h64);
    tk(8'h10, 1'h1, 0, 1'h1);
    tk(8'h00, 1'h0, 0, 1'h1);
    tk(8'h10, 1'h0, 0, 1'h0);
    @(posedge clk) updn <= 1'h0;
    tk(8'h00, 1'h0, 0, 1'h1);
    wr(A_C0, 8'h6c);
    tk(8'h00, 1'h0, 0, 1'h1);
    tk(8'hff, 1'h0, 0, 1'h0);
    tk(8'h10, 1'h0, 0, 1'h1);
    wr(A_C0, 8'h74);
    tk(8'h10, 1'h0, 0, 1'h0);
    tk(8'hff, 1'h0, 0, 1'h0);
    tk(8'h00, 1'h0, 0, 1'h1);
    wr(A_C0, 8'h7c);
    tk(8'h10, 1'h0, 0, 1'h1);
    tk(8'hff, 1'h0, 0, 1'h1);
    wr(A_V1, 8'h30);
    rc(A_V1, 8'h30);
    tk(8'h30, 1'h0, 1, 1'h0);
    wr(A_C1, 8'h44);
    tk(8'h10, 1'h0, 1, 1'h0);
    wr(A_FL, 8'h00);
    tk(8'h30, 1'h0, 1, 1'h1);
    rc(A_FL, 8'h20);
    chk("ch_irq", {30'h0, ch_irq}, 32'h2);
    wr(A_C1, 8'h6c);
    tk(8'h10, 1'h0, 1, 1'h0);
    tk(8'h30, 1'h0, 1, 1'h1);
    tk(8'hff, 1'h0, 1, 1'h1);
    wr(A_C1, 8'h74);
    tk(8'h30, 1'h0, 1, 1'h0);
    tk(8'h10, 1'h0, 1, 1'h1);
    // Masking channel one with its flag pending drops only its request
    wr(A_C1, 8'h34);
    chk("ch_irq", {30'h0, ch_irq}, 32'h1);
    rc(A_FL, 8'h30);
    summarize();
  end
endmodule : tb_tcc_top
